/* logic/bank_ext_defs.vh */
// Purpose: constants for the memory bank extension controller
// Assumes: 12-bit processor word, 3-bit bank numbers, eight 4K banks
// Notes: io transfer function codes are local choices for this block
`ifndef BANK_EXT_DEFS_VH
`define BANK_EXT_DEFS_VH

`define BANK_W          3
`define WORD_W          12
`define BANK_COUNT      8
`define BANK_WORDS      4096
`define TOTAL_WORDS     32768
`define BANK_RESET      3'h0

// major states presented by the processor
`define MAJ_FETCH       2'h0
`define MAJ_DEFER       2'h1
`define MAJ_EXECUTE     2'h2

// io transfer device code and function codes (low three bits of the instruction)
`define DEV_CODE_W      3
`define DEV_CODE        3'h2
`define FN_CDF          3'h1
`define FN_CIF          3'h2
`define FN_CIDF         3'h3
`define FN_RD_DF        3'h4
`define FN_RD_IF        3'h5
`define FN_RD_SAVE      3'h6
`define FN_RMF          3'h7

// opcode field of the instruction word
`define OP_IOT          3'h6
`define OP_OPR          3'h7
`define HLT_BIT         1
`define OSR_BIT         2
`define OPR_GROUP2_BIT  8
`define OPR_GROUP_BIT   0
`define IOT_RTF_CODE    9'h005
`define CAUSE_HLT       2'h1
`define CAUSE_OSR       2'h2
`define CAUSE_IOT       2'h3

`endif

/* logic/bank_save_buf.v */
// Purpose: save buffer holding code and operand bank at interrupt entry
// Assumes: single clock, asynchronous active-high reset
// Notes: read data comes straight out of the capture registers; there is no read request
`timescale 1ns/10ps
`include "bank_ext_defs.vh"

module bank_save_buf (
    // clock and reset
    input  wire                 clk_i,
    input  wire                 rst_i,
    // capture side
    input  wire                 save_i,
    input  wire [`BANK_W-1:0]   code_bank_i,
    input  wire [`BANK_W-1:0]   oper_bank_i,
    input  wire                 user_i,
    // read side
    output reg  [`BANK_W-1:0]   code_save_o,
    output reg  [`BANK_W-1:0]   oper_save_o,
    output reg                  user_save_o
);

    // capture on interrupt entry only, so data breaks never touch the copy
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            code_save_o <= `BANK_RESET;
            oper_save_o <= `BANK_RESET;
            user_save_o <= 1'b0;
        end else if (save_i) begin
            code_save_o <= code_bank_i;
            oper_save_o <= oper_bank_i;
            user_save_o <= user_i;
        end
    end

endmodule // bank_save_buf

/* logic/memory_field_extension.v */
// Purpose: memory bank extension controller for a 12-bit processor
// Assumes: processor bus inputs synchronous to clk_i; one instruction per strobe
// Notes: jumper input ts_enable_i low disables every time-share function
`timescale 1ns/10ps
`include "bank_ext_defs.vh"

module memory_field_extension (
    // clock and reset
    input  wire                 clk_i,
    input  wire                 rst_i,
    // build-time jumper: high lets time-share logic work
    input  wire                 ts_enable_i,
    // processor state
    input  wire [1:0]           major_state_i,
    input  wire                 indirect_i,
    input  wire                 instr_valid_i,
    input  wire [`WORD_W-1:0]   instr_i,
    input  wire                 instr_done_i,
    input  wire                 jmp_jms_i,
    input  wire                 int_entry_i,
    input  wire [`WORD_W-1:0]   ac_i,
    // console
    input  wire                 console_load_code_i,
    input  wire                 console_load_oper_i,
    input  wire [`BANK_W-1:0]   switch_bank_i,
    // data break
    input  wire                 break_i,
    // bank lines toward memory
    output reg  [`BANK_W-1:0]   ext_bank_lines_o,
    output reg                  ext_bank_oe_o,
    // data bus back to the processor
    output reg  [`WORD_W-1:0]   data_o,
    output reg                  data_oe_o,
    // control back to the processor
    output reg                  int_inhibit_o,
    output reg                  user_mode_o,
    output reg                  irq_line_o,
    output reg                  skip_o,
    output reg  [1:0]           trap_cause_o
);

    // bank and mode state
    reg [`BANK_W-1:0] code_bank_reg;     // one of eight 4K banks
    reg [`BANK_W-1:0] operand_bank_reg;
    reg [`BANK_W-1:0] code_pend_reg;
    reg               code_pend_valid_reg;
    reg               user_reg;
    reg               user_pend_reg;
    reg               user_trap_reg;
    reg               inhibit_reg;

    wire [`BANK_W-1:0] code_save;
    wire [`BANK_W-1:0] oper_save;
    wire               user_save;

    // instruction decode
    wire [2:0] opcode  = instr_i[11:9];
    wire       is_iot  = instr_valid_i && (opcode == `OP_IOT);
    wire       is_ours = is_iot && (instr_i[8:6] == 3'h2);
    wire [2:0] fn      = instr_i[2:0];
    wire [2:0] fbank   = instr_i[5:3];
    wire       rd_grp  = is_ours && (instr_i[5:3] == 3'h1);
    wire       chg_grp = is_ours && !rd_grp;
    wire       is_rtf  = is_iot && (instr_i[8:0] == `IOT_RTF_CODE);
    wire       op_cdf  = chg_grp && fn[0];
    wire       op_cif  = chg_grp && fn[1];
    // restore-bank shares function 4 with the status read: one strobe does both
    wire       op_rmf  = rd_grp && (fn == 3'h4);
    wire       is_hlt  = instr_valid_i && (opcode == `OP_OPR) && instr_i[`OPR_GROUP2_BIT]
                         && !instr_i[`OPR_GROUP_BIT] && instr_i[`HLT_BIT];
    wire       is_osr  = instr_valid_i && (opcode == `OP_OPR) && instr_i[`OPR_GROUP2_BIT]
                         && !instr_i[`OPR_GROUP_BIT] && instr_i[`OSR_BIT];
    wire       ts_on   = ts_enable_i;
    wire       trap    = ts_on && user_reg && (is_hlt || is_osr || is_iot);

    // read group strobes, one per function code
    wire       rd_skip   = rd_grp && (fn == 3'h0);
    wire       rd_oper   = rd_grp && (fn == 3'h1);
    wire       rd_code   = rd_grp && (fn == 3'h2);
    wire       rd_status = rd_grp && (fn == 3'h4);
    wire       rd_saved  = rd_grp && (fn == 3'h6);
    // only these four drive the data bus; the skip test answers on skip_o alone
    wire       rd_any    = rd_oper || rd_code || rd_status || rd_saved;

    // bank changes that the trap logic lets through, and the jump that ends them
    wire       bank_chg  = (op_cif || op_rmf || is_rtf) && !trap;
    wire       jump_done = jmp_jms_i && instr_done_i;

    // trap cause: a halt ranks first, then a switch read, anything else is io
    reg  [1:0]         cause_next;
    always @* begin
        cause_next = `CAUSE_IOT;
        if (is_hlt)
            cause_next = `CAUSE_HLT;
        else if (is_osr)
            cause_next = `CAUSE_OSR;
    end

    // word offered by the read functions; status packs user flag and both banks
    reg  [`WORD_W-1:0] data_next;
    always @* begin
        case (fn)
            3'h1:    data_next = {6'h00, operand_bank_reg, 3'h0};
            3'h2:    data_next = {6'h00, code_bank_reg, 3'h0};
            3'h4:    data_next = {5'h00, user_reg, code_bank_reg, operand_bank_reg};
            3'h6:    data_next = {5'h00, user_save, code_save, oper_save};
            default: data_next = 12'h000;
        endcase
    end

    // bank register put on the lines, from major state and the indirect flag
    reg  [`BANK_W-1:0] lines_next;
    always @* begin
        case (major_state_i)
            `MAJ_FETCH:   lines_next = code_bank_reg;
            `MAJ_DEFER:   lines_next = code_bank_reg;
            `MAJ_EXECUTE: lines_next = indirect_i ? operand_bank_reg
                                                  : code_bank_reg;
            default:      lines_next = code_bank_reg;
        endcase
    end

    bank_save_buf u_save (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .save_i      (int_entry_i),
        .code_bank_i (code_bank_reg),
        .oper_bank_i (operand_bank_reg),
        .user_i      (user_reg),
        .code_save_o (code_save),
        .oper_save_o (oper_save),
        .user_save_o (user_save)
    );

    // bank registers: console, io transfer, restore, interrupt entry
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            code_bank_reg       <= `BANK_RESET;
            operand_bank_reg    <= `BANK_RESET;
            code_pend_reg       <= `BANK_RESET;
            code_pend_valid_reg <= 1'b0;
            user_reg            <= 1'b0;
            user_pend_reg       <= 1'b0;
        end else if (break_i) begin
            // a data break leaves every bank register alone
            code_bank_reg <= code_bank_reg;
        end else if (int_entry_i) begin
            // interrupt runs in bank 0, monitor mode; old values kept in save buffer
            code_bank_reg       <= `BANK_RESET;
            operand_bank_reg    <= `BANK_RESET;
            code_pend_valid_reg <= 1'b0;
            user_reg            <= 1'b0;
        end else begin
            // console switches load either register directly
            if (console_load_code_i)
                code_bank_reg <= switch_bank_i;
            if (console_load_oper_i)
                operand_bank_reg <= switch_bank_i;
            // io transfers change banks; a trapped one changes nothing
            if (op_cdf && !trap)
                operand_bank_reg <= fbank;
            if (op_cif && !trap) begin
                code_pend_reg       <= fbank;
                code_pend_valid_reg <= 1'b1;
            end
            // restore-bank brings back what interrupt entry saved
            if (op_rmf && !trap) begin
                operand_bank_reg    <= oper_save;
                code_pend_reg       <= code_save;
                code_pend_valid_reg <= 1'b1;
                user_pend_reg       <= user_save;
            end
            // restore-flags takes both banks and the user flag from the accumulator
            if (is_rtf && !trap) begin
                operand_bank_reg    <= ac_i[2:0];
                code_pend_reg       <= ac_i[5:3];
                code_pend_valid_reg <= 1'b1;
                user_pend_reg       <= ts_on & ac_i[6];
            end
            // a pending code bank takes hold at the next jump, as software expects
            if (jmp_jms_i && code_pend_valid_reg) begin
                code_bank_reg       <= code_pend_reg;
                code_pend_valid_reg <= 1'b0;
                user_reg            <= ts_on & user_pend_reg;
            end
        end
    end

    // interrupt inhibit: held from bank change until the jump completes it
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            inhibit_reg <= 1'b0;
        else if (bank_chg)
            inhibit_reg <= 1'b1;
        else if (jump_done)
            inhibit_reg <= 1'b0;
    end

    // user trap flag; set beats the clearing read in the same cycle
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            user_trap_reg <= 1'b0;
            trap_cause_o  <= 2'h0;
        end else if (trap) begin
            user_trap_reg <= 1'b1;
            trap_cause_o  <= cause_next;
        end else if (rd_saved && !user_reg) begin
            // monitor reads the saved word and thereby acknowledges the trap
            user_trap_reg <= 1'b0;
        end else if (!ts_on) begin
            user_trap_reg <= 1'b0;
        end
    end

    // bank line selection from major state and indirect flag
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_bank_lines_o <= `BANK_RESET;
            ext_bank_oe_o    <= 1'b0;
        end else if (break_i) begin
            ext_bank_lines_o <= `BANK_RESET;
            ext_bank_oe_o    <= 1'b0;
        end else begin
            ext_bank_oe_o    <= 1'b1;
            ext_bank_lines_o <= lines_next;
        end
    end

    // bank read instructions drive the data bus for a store via the accumulator
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_o    <= 12'h000;
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= rd_any;
            data_o    <= data_next;
        end
    end

    // control outputs to the processor
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_inhibit_o <= 1'b0;
            user_mode_o   <= 1'b0;
            irq_line_o    <= 1'b0;
            skip_o        <= 1'b0;
        end else begin
            // drops with the completing jump, so the processor may interrupt at once
            int_inhibit_o <= (inhibit_reg && !jump_done) || bank_chg;
            user_mode_o   <= ts_on && user_reg;
            irq_line_o    <= ts_on && (user_trap_reg || trap);
            skip_o        <= ts_on && rd_skip && user_trap_reg;
        end
    end

endmodule // memory_field_extension

/* verif/mfe_sva.sv */
// Purpose: port checker for the bank extension controller
// Assumes: registered outputs, one cycle after the input edge
// Notes: bank values themselves are judged by the bench
`timescale 1ns/10ps
`include "bank_ext_defs.vh"
module mfe_sva (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               rst_i,
    // inputs watched
    input wire logic               ts_enable_i,
    input wire logic               instr_valid_i,
    input wire logic [`WORD_W-1:0] instr_i,
    input wire logic               instr_done_i,
    input wire logic               jmp_jms_i,
    input wire logic               break_i,
    // outputs watched
    input wire logic               ext_bank_oe_o,
    input wire logic               data_oe_o,
    input wire logic               int_inhibit_o,
    input wire logic               user_mode_o,
    input wire logic               irq_line_o,
    input wire logic [1:0]         trap_cause_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a change-code instruction of ours, not refused by user mode
    wire cif_take = instr_valid_i && instr_i[11:6] == 6'h32 && instr_i[5:3] != 3'h1
                    && instr_i[1] && !(user_mode_o && ts_enable_i);
    brk_quiet_a: assert property (break_i |=> !ext_bank_oe_o)
        else $error("bank lines driven during data break");
    drive_on_a: assert property (!break_i |=> ext_bank_oe_o)
        else $error("bank lines not driven outside data break");
    user_off_a: assert property (!ts_enable_i [*2] |-> !user_mode_o)
        else $error("user mode while jumper disables time share");
    irq_cause_a: assert property ($rose(irq_line_o) |-> trap_cause_o != 2'h0)
        else $error("trap request without a cause");
    irq_user_a: assert property ($rose(irq_line_o) |-> $past(user_mode_o))
        else $error("trap raised outside user mode");
    data_cause_a: assert property (data_oe_o |-> $past(instr_valid_i))
        else $error("data driven without an instruction");
    cif_inhibit_a: assert property (cif_take |=> int_inhibit_o)
        else $error("code bank change left interrupts open");
    inhibit_hold_a: assert property (int_inhibit_o && !(jmp_jms_i && instr_done_i)
        |=> int_inhibit_o)
        else $error("inhibit dropped before the jump completed");
endmodule // mfe_sva
bind memory_field_extension mfe_sva u_mfe_sva (.clk_i(clk_i), .rst_i(rst_i),
    .ts_enable_i(ts_enable_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_done_i(instr_done_i), .jmp_jms_i(jmp_jms_i), .break_i(break_i),
    .ext_bank_oe_o(ext_bank_oe_o), .data_oe_o(data_oe_o), .int_inhibit_o(int_inhibit_o),
    .user_mode_o(user_mode_o), .irq_line_o(irq_line_o), .trap_cause_o(trap_cause_o));

/* verif/bank_decode_model.sv */
// Purpose: memory banks and break peripheral on the far side of the bank lines
// Assumes: one responder per 4K bank, eight banks
// Notes: an undriven bus shows the inverse of its last value
`timescale 1ns/10ps
module bank_decode_model (
    // clock
    input  wire logic       clk_i,
    // bank lines from the device
    input  wire logic [2:0] lines_i,
    input  wire logic       oe_i,
    // data break peripheral
    input  wire logic       break_i,
    input  wire logic [2:0] brk_bank_i,
    // resolved bus and bank selects
    output logic      [2:0] bus_bank_o,
    output logic      [7:0] hit_o
);
    logic [2:0] last_reg = 3'h0;
    always_ff @(posedge clk_i) last_reg <= bus_bank_o;
    // stale numbers must never look valid, so a released bus keeps toggling
    always_comb begin
        if (oe_i) bus_bank_o = lines_i;
        else if (break_i) bus_bank_o = brk_bank_i;
        else bus_bank_o = ~last_reg;
        hit_o = 8'h00;
        if (oe_i || break_i) hit_o[bus_bank_o] = 1'b1;
    end
endmodule // bank_decode_model

/* verif/memory_field_extension_bench.sv */
// Purpose: self-checking bench for the bank extension controller
// Assumes: inputs change 5 ns after the rising edge
// Notes: data reads are queued and checked by a watcher process
`timescale 1ns/10ps
`include "bank_ext_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR at %0t got %h exp %h", $time, g, e); end end
module memory_field_extension_bench;
    logic clk_i = 0, rst_i = 1, ts_enable_i = 0, indirect_i = 0, instr_valid_i = 0;
    logic instr_done_i = 0, jmp_jms_i = 0, int_entry_i = 0, break_i = 0;
    logic console_load_code_i = 0, console_load_oper_i = 0;
    logic [1:0] major_state_i = 2'h0, trap_cause_o;
    logic [11:0] instr_i = 12'h000, ac_i = 12'h000, data_o, exp_q[$];
    logic [2:0] switch_bank_i = 3'h0, brk_bank = 3'h0, ext_bank_lines_o, bus_bank, c;
    logic [7:0] hit, lfsr_reg = 8'h2e;
    logic ext_bank_oe_o, data_oe_o, int_inhibit_o, user_mode_o, irq_line_o, skip_o;
    int errors = 0, total_checks = 0;
    always #50 clk_i = ~clk_i;
    memory_field_extension u_memory_field_extension (.clk_i(clk_i), .rst_i(rst_i),
        .ts_enable_i(ts_enable_i), .major_state_i(major_state_i), .indirect_i(indirect_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_done_i(instr_done_i),
        .jmp_jms_i(jmp_jms_i), .int_entry_i(int_entry_i), .ac_i(ac_i),
        .console_load_code_i(console_load_code_i), .console_load_oper_i(console_load_oper_i),
        .switch_bank_i(switch_bank_i), .break_i(break_i), .ext_bank_lines_o(ext_bank_lines_o),
        .ext_bank_oe_o(ext_bank_oe_o), .data_o(data_o), .data_oe_o(data_oe_o),
        .int_inhibit_o(int_inhibit_o), .user_mode_o(user_mode_o), .irq_line_o(irq_line_o),
        .skip_o(skip_o), .trap_cause_o(trap_cause_o));
    bank_decode_model u_bank_decode_model (.clk_i(clk_i), .lines_i(ext_bank_lines_o),
        .oe_i(ext_bank_oe_o), .break_i(break_i), .brk_bank_i(brk_bank),
        .bus_bank_o(bus_bank), .hit_o(hit));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic step();
        @(posedge clk_i);
        #5;
    endtask
    task automatic issue(input logic [11:0] w);
        instr_valid_i = 1;
        instr_i = w;
        step();
        instr_valid_i = 0;
    endtask
    // set the major state, let the lines settle, then see which bank answers
    task automatic look(input logic [1:0] st, input logic ind, input logic [2:0] b);
        major_state_i = st;
        indirect_i = ind;
        step();
        `CHK(ext_bank_oe_o, 1'b1)
        `CHK(hit, 8'h01 << b)
    endtask
    task automatic conclude();
        `CHK(exp_q.size(), 0)
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watcher: each data read result is matched with the oldest note
    always @(negedge clk_i) begin
        if (data_oe_o === 1'b1) begin
            if (exp_q.size() == 0) `CHK(data_o, 12'hfff)
            else `CHK(data_o, exp_q.pop_front())
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        #5 rst_i = 0;
        `CHK({ext_bank_lines_o, int_inhibit_o, user_mode_o, irq_line_o}, 6'h00)
        look(`MAJ_FETCH, 0, 3'h0);
        // every bank through the console, code bank drawn at random
        for (int b = 0; b < 8; b++) begin
            lfsr_reg = lfsr(lfsr_reg);
            c = lfsr_reg[2:0];
            console_load_code_i = 1;
            switch_bank_i = c;
            step();
            console_load_code_i = 0;
            console_load_oper_i = 1;
            switch_bank_i = b[2:0];
            step();
            console_load_oper_i = 0;
            look(`MAJ_FETCH, 0, c);
            look(`MAJ_EXECUTE, 1, b[2:0]);
            look(`MAJ_EXECUTE, 0, c);
            exp_q.push_back({6'h00, b[2:0], 3'h0});
            issue({3'h6, 3'h2, 3'h1, 3'h1});
            step();
            exp_q.push_back({6'h00, c, 3'h0});
            issue({3'h6, 3'h2, 3'h1, 3'h2});
        end
        step();
        // code bank change waits for the jump, interrupts held meanwhile
        issue({3'h6, 3'h2, 3'h5, 3'h2});
        `CHK(int_inhibit_o, 1'b1)
        look(`MAJ_FETCH, 0, c);
        {jmp_jms_i, instr_done_i} = 2'h3;
        step();
        {jmp_jms_i, instr_done_i} = 2'h0;
        look(`MAJ_FETCH, 0, 3'h5);
        `CHK(int_inhibit_o, 1'b0)
        issue({3'h6, 3'h2, 3'h6, 3'h1});
        look(`MAJ_EXECUTE, 1, 3'h6);
        // data break: peripheral owns the lines, banks survive it
        break_i = 1;
        brk_bank = 3'h3;
        step();
        `CHK(ext_bank_oe_o, 1'b0)
        `CHK(hit, 8'h08)
        break_i = 0;
        look(`MAJ_EXECUTE, 1, 3'h6);
        // time share: enter user mode, then trap a halt and an io instruction
        ts_enable_i = 1;
        ac_i = 12'h054;
        issue(12'hc05);
        {jmp_jms_i, instr_done_i} = 2'h3;
        step();
        {jmp_jms_i, instr_done_i} = 2'h0;
        step();
        `CHK(user_mode_o, 1'b1)
        issue(12'hf02);
        step();
        `CHK(irq_line_o, 1'b1)
        `CHK(trap_cause_o, 2'h1)
        issue({3'h6, 3'h2, 3'h2, 3'h1});
        step();
        `CHK(trap_cause_o, 2'h3)
        look(`MAJ_EXECUTE, 1, 3'h4);
        // interrupt entry: monitor mode, trap skip and acknowledge, banks restored
        int_entry_i = 1;
        step();
        int_entry_i = 0;
        look(`MAJ_FETCH, 0, 3'h0);
        issue({3'h6, 3'h2, 3'h1, 3'h0});
        `CHK(skip_o, 1'b1)
        step();
        exp_q.push_back(12'h054);
        issue({3'h6, 3'h2, 3'h1, 3'h6});
        step();
        `CHK(irq_line_o, 1'b0)
        exp_q.push_back(12'h000);
        issue({3'h6, 3'h2, 3'h1, 3'h4});
        `CHK(int_inhibit_o, 1'b1)
        look(`MAJ_EXECUTE, 1, 3'h4);
        {jmp_jms_i, instr_done_i} = 2'h3;
        step();
        {jmp_jms_i, instr_done_i} = 2'h0;
        look(`MAJ_FETCH, 0, 3'h2);
        `CHK(user_mode_o, 1'b1)
        ts_enable_i = 0;
        step();
        step();
        `CHK(user_mode_o, 1'b0)
        conclude();
    end
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #500000;
        errors++;
        conclude();
    end
endmodule // memory_field_extension_bench
